// file: rtl/ioi_map.svh
`ifndef IOI_MAP_SVH
`define IOI_MAP_SVH
`define IOI_ENTRY_W 17
`define IOI_ENTRY_RST 17'h1_0000
`define IOI_ENTRY_WMASK 17'h1_AFFF
`define IOI_VEC_LSB 0
`define IOI_VEC_MSB 7
`define IOI_DM_LSB 8
`define IOI_DM_MSB 10
`define IOI_DS_BIT 12
`define IOI_RIRR_BIT 14
`define IOI_TRIG_BIT 15
`define IOI_MASK_BIT 16
`define IOI_DM_FIXED 3'h0
`define IOI_DM_LOWEST 3'h1
`define IOI_DM_SMI 3'h2
`define IOI_DM_RSV3 3'h3
`define IOI_DM_NMI 3'h4
`define IOI_DM_INIT 3'h5
`define IOI_DM_RSV6 3'h6
`define IOI_DM_EXT 3'h7
`define IOI_VEC_ZERO 8'h00
`define IOI_VEC_MIN 8'h10
`define IOI_VEC_MAX 8'hFE
`define IOI_NCORES 4
`define IOI_PRIO_W 4
`define IOI_PRIO_MAX 4'hF
`endif

// file: rtl/ioi_pkg.sv
`include "ioi_map.svh"
package ioi_pkg;
	typedef enum logic [2:0] {
		IOI_FIXED = `IOI_DM_FIXED,
		IOI_LOWEST = `IOI_DM_LOWEST,
		IOI_SMI = `IOI_DM_SMI,
		IOI_RSV3 = `IOI_DM_RSV3,
		IOI_NMI = `IOI_DM_NMI,
		IOI_INIT = `IOI_DM_INIT,
		IOI_RSV6 = `IOI_DM_RSV6,
		IOI_EXT = `IOI_DM_EXT
	} ioi_mode_t;
	typedef enum logic [2:0] {
		IOI_D_IDLE = 3'h1,
		IOI_D_SEND = 3'h2,
		IOI_D_WEOI = 3'h4
	} ioi_dev_st_t;
	typedef enum logic [1:0] {
		IOI_L_IDLE = 2'h1,
		IOI_L_INTA = 2'h2
	} ioi_lu_st_t;
	function automatic logic ioi_mode_reserved(input logic [2:0] m);
		return (m == `IOI_DM_RSV3) || (m == `IOI_DM_RSV6);
	endfunction
	function automatic logic ioi_edge_only(input logic [2:0] m);
		return (m == `IOI_DM_SMI) || (m == `IOI_DM_NMI) || (m == `IOI_DM_INIT) || (m == `IOI_DM_EXT);
	endfunction
endpackage

// file: rtl/ioi_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ioi_link_if;
	logic msg_valid;
	logic [2:0] msg_mode;
	logic [7:0] msg_vector;
	logic msg_level;
	logic msg_accept;
	logic msg_eoi;
	logic [7:0] eoi_vector;
	logic inta_req;
	logic inta_valid;
	logic [7:0] inta_vector;
	modport dev (
		output msg_valid, msg_mode, msg_vector, msg_level, inta_valid, inta_vector,
		input msg_accept, msg_eoi, eoi_vector, inta_req
	);
	modport lu (
		input msg_valid, msg_mode, msg_vector, msg_level, inta_valid, inta_vector,
		output msg_accept, msg_eoi, eoi_vector, inta_req
	);
endinterface
`default_nettype wire

// file: rtl/ioi_lu_end.sv
`timescale 1ns/10ps
`default_nettype none
`include "ioi_map.svh"
module ioi_lu_end
	import ioi_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	ioi_link_if.lu link,
	input wire logic [`IOI_NCORES-1:0] core_dest,
	input wire logic [`IOI_NCORES*`IOI_PRIO_W-1:0] core_prio,
	input wire logic core_eoi,
	input wire logic [`IOI_NCORES-1:0] core_init_clr,
	output logic [`IOI_NCORES-1:0] core_int_q,
	output logic [`IOI_NCORES-1:0] core_nmi_q,
	output logic [`IOI_NCORES-1:0] core_smi_q,
	output logic [`IOI_NCORES-1:0] core_init_q,
	output logic [`IOI_NCORES-1:0] core_in_init_q,
	output logic [7:0] core_vector_q,
	output logic core_vec_valid_q
);
	ioi_lu_st_t st_q;
	logic accept_q;
	logic eoi_q;
	logic [7:0] eoi_vec_q;
	logic inta_req_q;
	logic [`IOI_NCORES-1:0] ext_dest_q;
	logic [`IOI_NCORES-1:0] lowest;
	logic take;

	// Ties go to the lowest-numbered core
	function automatic logic [`IOI_NCORES-1:0] pick_lowest(input logic [`IOI_NCORES-1:0] d,
		input logic [`IOI_NCORES*`IOI_PRIO_W-1:0] p);
		logic [`IOI_NCORES-1:0] r;
		logic [`IOI_PRIO_W-1:0] best;
		logic found;
		r = '0;
		best = `IOI_PRIO_MAX;
		found = 1'b0;
		for (int i = 0; i < `IOI_NCORES; i++) begin
			if (d[i] && (!found || p[i*`IOI_PRIO_W +: `IOI_PRIO_W] < best)) begin
				best = p[i*`IOI_PRIO_W +: `IOI_PRIO_W];
				r = '0;
				r[i] = 1'b1;
				found = 1'b1;
			end
		end
		return r;
	endfunction

	assign lowest = pick_lowest(core_dest, core_prio);
	assign take = link.msg_valid && !accept_q && (st_q == IOI_L_IDLE);
	assign link.msg_accept = accept_q;
	assign link.msg_eoi = eoi_q;
	assign link.eoi_vector = eoi_vec_q;
	assign link.inta_req = inta_req_q;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_q <= IOI_L_IDLE;
			ext_dest_q <= '0;
		end else begin
			case (st_q)
				IOI_L_IDLE: begin
					if (take && link.msg_mode == `IOI_DM_EXT) begin
						st_q <= IOI_L_INTA;
						ext_dest_q <= core_dest;
					end
				end
				IOI_L_INTA: begin
					if (link.inta_valid) begin
						st_q <= IOI_L_IDLE;
					end
				end
				default: st_q <= IOI_L_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			accept_q <= 1'b0;
			inta_req_q <= 1'b0;
		end else begin
			accept_q <= take;
			inta_req_q <= take && (link.msg_mode == `IOI_DM_EXT);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			core_int_q <= '0;
			core_nmi_q <= '0;
			core_smi_q <= '0;
			core_init_q <= '0;
			core_vector_q <= `IOI_VEC_ZERO;
			core_vec_valid_q <= 1'b0;
		end else begin
			core_int_q <= '0;
			core_nmi_q <= '0;
			core_smi_q <= '0;
			core_init_q <= '0;
			core_vec_valid_q <= 1'b0;
			if (take) begin
				case (link.msg_mode)
					`IOI_DM_FIXED: begin
						core_int_q <= core_dest;
						core_vector_q <= link.msg_vector;
						core_vec_valid_q <= 1'b1;
					end
					`IOI_DM_LOWEST: begin
						core_int_q <= lowest;
						core_vector_q <= link.msg_vector;
						core_vec_valid_q <= 1'b1;
					end
					`IOI_DM_SMI: core_smi_q <= core_dest;
					`IOI_DM_NMI: core_nmi_q <= core_dest;
					`IOI_DM_INIT: core_init_q <= core_dest;
					default: begin
					end
				endcase
			end else if (st_q == IOI_L_INTA && link.inta_valid) begin
				// Vector of an external-controller interrupt comes from its acknowledge cycle
				core_int_q <= ext_dest_q;
				core_vector_q <= link.inta_vector;
				core_vec_valid_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			core_in_init_q <= '0;
		end else begin
			// Set wins over clear
			core_in_init_q <= (core_in_init_q & ~core_init_clr) |
				((take && link.msg_mode == `IOI_DM_INIT) ? core_dest : '0);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			eoi_q <= 1'b0;
			eoi_vec_q <= `IOI_VEC_ZERO;
		end else begin
			eoi_q <= core_eoi;
			if (core_eoi) begin
				eoi_vec_q <= core_vector_q;
			end
		end
	end
endmodule
`default_nettype wire

// file: rtl/ioi_dev_end.sv
`timescale 1ns/10ps
`default_nettype none
`include "ioi_map.svh"
// Function
// RULE1 - Three-bit delivery mode at bits 10:8, R/W
// RULE2 - Mode 000 delivers maskable to all destinations
// RULE3 - Mode 001 goes to lowest-priority destination
// RULE4 - Software sets edge trigger for SMI mode
// RULE5 - SMI ignores vector; software programs zero
// RULE6 - Mode 100 delivers non-maskable, vector ignored
// RULE7 - Software sets edge trigger for NMI mode
// RULE8 - Mode 101 asserts initialise on destinations
// RULE9 - Software sets edge trigger for initialise mode
// RULE10 - Mode 111: external controller supplies vector
// RULE11 - Software sets edge trigger for external mode
// RULE12 - Eight-bit R/W vector at bits 7:0
// RULE13 - Software programs vectors 10h to FEh only
// RULE14 - Software avoids reserved modes 011 and 110
// RULE15 - Bit 15 selects level (1) or edge (0)
// RULE16 - Masked inputs ignored, not held pending
module ioi_dev_end
	import ioi_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	ioi_link_if.dev link,
	input wire logic irq_pin,
	input wire logic entry_wr,
	input wire logic [`IOI_ENTRY_W-1:0] entry_wr_data,
	input wire logic [7:0] ext_vector,
	output logic [`IOI_ENTRY_W-1:0] entry_rd_q,
	output logic ext_inta_q,
	output logic pending_q,
	output logic cfg_err_q,
	output logic vec_range_err_q
);
	logic pin_s1_q;
	logic pin_s2_q;
	logic pin_s3_q;
	logic [`IOI_ENTRY_W-1:0] entry_q;
	logic remote_irr_q;
	ioi_dev_st_t st_q;
	logic msg_valid_q;
	logic [2:0] msg_mode_q;
	logic [7:0] msg_vector_q;
	logic msg_level_q;
	logic inta_valid_q;
	logic [7:0] inta_vector_q;
	logic [2:0] mode;
	logic [7:0] vec;
	logic level_trig;
	logic masked;
	logic rise;
	logic level_req;
	logic req;
	logic launch;
	logic [`IOI_ENTRY_W-1:0] entry_d;

	assign mode = entry_q[`IOI_DM_MSB:`IOI_DM_LSB]; // RULE1
	assign vec = entry_q[`IOI_VEC_MSB:`IOI_VEC_LSB]; // RULE12
	assign level_trig = entry_q[`IOI_TRIG_BIT]; // RULE15
	assign masked = entry_q[`IOI_MASK_BIT];
	assign rise = pin_s2_q && !pin_s3_q;
	assign level_req = level_trig && pin_s2_q && !masked && !remote_irr_q; // RULE16
	assign req = level_trig ? level_req : pending_q;
	// Reserved codes are dropped, with cfg_err_q raised, rather than sent with an unknown meaning
	assign launch = (st_q == IOI_D_IDLE) && req && !ioi_mode_reserved(mode); // RULE14

	assign link.msg_valid = msg_valid_q;
	assign link.msg_mode = msg_mode_q;
	assign link.msg_vector = msg_vector_q;
	assign link.msg_level = msg_level_q;
	assign link.inta_valid = inta_valid_q;
	assign link.inta_vector = inta_vector_q;

	// Pin is asynchronous to ref_clk
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			pin_s3_q <= 1'b0;
		end else begin
			pin_s1_q <= irq_pin;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// Read-only bits are never stored from a write
	always_comb begin
		entry_d = entry_q;
		if (entry_wr) begin
			entry_d = entry_wr_data & `IOI_ENTRY_WMASK; // RULE1 RULE12 RULE15
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			entry_q <= `IOI_ENTRY_RST;
		end else begin
			entry_q <= entry_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			entry_rd_q <= `IOI_ENTRY_RST;
		end else begin
			entry_rd_q <= entry_q;
			entry_rd_q[`IOI_DS_BIT] <= (st_q == IOI_D_SEND);
			entry_rd_q[`IOI_RIRR_BIT] <= remote_irr_q;
		end
	end

	// Edge capture; a new edge in the launch cycle is kept, set wins
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pending_q <= 1'b0;
		end else if (level_trig) begin
			pending_q <= 1'b0;
		end else if (rise && !masked) begin
			pending_q <= 1'b1; // RULE16
		end else if ((st_q == IOI_D_IDLE) && pending_q) begin
			pending_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_q <= IOI_D_IDLE;
		end else begin
			case (st_q)
				IOI_D_IDLE: begin
					if (launch) begin
						st_q <= IOI_D_SEND;
					end
				end
				IOI_D_SEND: begin
					if (link.msg_accept) begin
						st_q <= msg_level_q ? IOI_D_WEOI : IOI_D_IDLE;
					end
				end
				IOI_D_WEOI: begin
					st_q <= IOI_D_IDLE;
				end
				default: st_q <= IOI_D_IDLE;
			endcase
		end
	end

	// Level interrupts wait for a matching end-of-interrupt before resending
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			remote_irr_q <= 1'b0;
		end else if (st_q == IOI_D_SEND && link.msg_accept && msg_level_q) begin
			remote_irr_q <= 1'b1;
		end else if (link.msg_eoi && link.eoi_vector == vec) begin
			remote_irr_q <= 1'b0;
		end else if (!level_trig) begin
			remote_irr_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			msg_valid_q <= 1'b0;
			msg_mode_q <= `IOI_DM_FIXED;
			msg_vector_q <= `IOI_VEC_ZERO;
			msg_level_q <= 1'b0;
		end else if (launch) begin
			msg_valid_q <= 1'b1;
			msg_mode_q <= mode; // RULE2 RULE3 RULE6 RULE8 RULE10
			msg_level_q <= level_trig;
			case (mode)
				`IOI_DM_FIXED: msg_vector_q <= vec; // RULE2
				`IOI_DM_LOWEST: msg_vector_q <= vec; // RULE3
				`IOI_DM_SMI: msg_vector_q <= `IOI_VEC_ZERO; // RULE5
				`IOI_DM_NMI: msg_vector_q <= `IOI_VEC_ZERO; // RULE6
				`IOI_DM_INIT: msg_vector_q <= `IOI_VEC_ZERO; // RULE8
				`IOI_DM_EXT: msg_vector_q <= `IOI_VEC_ZERO; // RULE10
				default: msg_vector_q <= `IOI_VEC_ZERO;
			endcase
		end else if (st_q == IOI_D_SEND && link.msg_accept) begin
			msg_valid_q <= 1'b0;
		end
	end

	// Acknowledge cycle goes to the external controller, which supplies the vector
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ext_inta_q <= 1'b0;
			inta_valid_q <= 1'b0;
			inta_vector_q <= `IOI_VEC_ZERO;
		end else begin
			ext_inta_q <= link.inta_req; // RULE10
			inta_valid_q <= ext_inta_q;
			if (ext_inta_q) begin
				inta_vector_q <= ext_vector; // RULE10
			end
		end
	end

	// Flags only; apart from a reserved mode, which never launches, the entry still delivers as programmed
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cfg_err_q <= 1'b0;
			vec_range_err_q <= 1'b0;
		end else begin
			cfg_err_q <= (ioi_edge_only(mode) && level_trig) || ioi_mode_reserved(mode); // RULE4 RULE7 RULE9 RULE11 RULE14
			vec_range_err_q <= ((mode == `IOI_DM_FIXED) || (mode == `IOI_DM_LOWEST)) &&
				((vec < `IOI_VEC_MIN) || (vec > `IOI_VEC_MAX)); // RULE13
		end
	end
endmodule
`default_nettype wire

// file: verif/ioi_link_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module ioi_link_asserts
	import ioi_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic msg_valid,
	input wire logic [2:0] msg_mode,
	input wire logic [7:0] msg_vector,
	input wire logic msg_accept,
	input wire logic msg_eoi,
	input wire logic inta_req,
	input wire logic inta_valid
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	a_vec_zeroed: assert property (msg_valid && msg_mode inside {3'h2, 3'h4, 3'h5, 3'h7} |-> msg_vector == 8'h00)
		else $error("vector not zero in a vectorless mode");
	a_no_reserved: assert property (msg_valid |-> !(msg_mode inside {3'h3, 3'h6}))
		else $error("message sent with a reserved mode");
	a_msg_holds: assert property (msg_valid && !msg_accept |=> msg_valid && $stable(msg_mode) && $stable(msg_vector))
		else $error("message changed before accept");
	a_msg_drops: assert property (msg_accept |=> !msg_valid)
		else $error("message held after accept");
	a_accept_pulse: assert property (msg_accept |-> $past(msg_valid) && !$past(msg_accept))
		else $error("accept without a message");
	a_inta_on_ext: assert property (inta_req |-> msg_accept && msg_mode == 3'h7)
		else $error("vector request outside external mode");
	a_inta_answer: assert property (inta_req |-> ##2 inta_valid ##1 !inta_valid)
		else $error("external vector not returned in time");
	a_eoi_pulse: assert property (msg_eoi |=> !msg_eoi)
		else $error("end of interrupt longer than one cycle");
endmodule
`default_nettype wire

// file: verif/ioint_delivery_mode_vector_test.sv
`timescale 1ns/10ps
`default_nettype none
module ioint_delivery_mode_vector_test
	import ioi_pkg::*;
;
	logic ref_clk, srst, irq_pin, entry_wr, core_eoi, s_lvl;
	logic ext_inta_q, pending_q, cfg_err_q, vec_range_err_q, core_vec_valid_q;
	logic [16:0] entry_wr_data, entry_rd_q;
	logic [7:0] ext_vector, core_vector_q, s_vec;
	logic [3:0] core_dest, core_init_clr, core_int_q, core_nmi_q, core_smi_q, core_init_q, core_in_init_q;
	logic [3:0] s_int, s_nmi, s_smi, s_init;
	logic s_vv, s_ext;
	logic [15:0] core_prio;
	ioi_mode_t m;
	ioi_mode_t modes[6] = '{IOI_FIXED, IOI_LOWEST, IOI_SMI, IOI_NMI, IOI_INIT, IOI_EXT};
	int failures, comparisons;
	ioi_link_if link();
	ioi_dev_end i_ioi_dev_end(.ref_clk, .srst, .link, .irq_pin, .entry_wr, .entry_wr_data, .ext_vector,
		.entry_rd_q, .ext_inta_q, .pending_q, .cfg_err_q, .vec_range_err_q);
	ioi_lu_end i_ioi_lu_end(.ref_clk, .srst, .link, .core_dest, .core_prio, .core_eoi, .core_init_clr,
		.core_int_q, .core_nmi_q, .core_smi_q, .core_init_q, .core_in_init_q, .core_vector_q, .core_vec_valid_q);
	ioi_link_asserts i_ioi_link_asserts(.ref_clk, .srst, .msg_valid(link.msg_valid), .msg_mode(link.msg_mode),
		.msg_vector(link.msg_vector), .msg_accept(link.msg_accept), .msg_eoi(link.msg_eoi),
		.inta_req(link.inta_req), .inta_valid(link.inta_valid));
	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [16:0] d);
		@(posedge ref_clk);
		entry_wr <= 1'b1;
		entry_wr_data <= d;
		@(posedge ref_clk);
		entry_wr <= 1'b0;
		tick(2);
	endtask
	// Pin held high for a while; nothing may leave the device
	task automatic quiet();
		logic seen;
		seen = 1'b0;
		@(posedge ref_clk);
		irq_pin <= 1'b1;
		repeat (8) begin
			tick(1);
			seen |= link.msg_valid;
		end
		check(seen, 17'h0_0000);
		@(posedge ref_clk);
		irq_pin <= 1'b0;
		tick(4);
	endtask
	// Core pulses are gathered over a few cycles since the external mode answers late
	task automatic fire();
		int k;
		s_int = 4'h0;
		s_nmi = 4'h0;
		s_smi = 4'h0;
		s_init = 4'h0;
		s_vv = 1'b0;
		s_ext = 1'b0;
		@(posedge ref_clk);
		irq_pin <= 1'b1;
		tick(1);
		k = 0;
		while (link.msg_accept !== 1'b1 && k < 20) begin
			tick(1);
			k++;
		end
		check(link.msg_accept, 17'h0_0001);
		s_vec = link.msg_vector;
		s_lvl = link.msg_level;
		for (k = 0; k < 5; k++) begin
			s_int |= core_int_q;
			s_nmi |= core_nmi_q;
			s_smi |= core_smi_q;
			s_init |= core_init_q;
			s_vv |= core_vec_valid_q;
			s_ext |= ext_inta_q;
			tick(1);
		end
		@(posedge ref_clk);
		irq_pin <= 1'b0;
		tick(6);
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		failures++;
		stop_test();
	end
	initial begin
		srst = 1'b1;
		irq_pin = 1'b0;
		entry_wr = 1'b0;
		entry_wr_data = 17'h0_0000;
		ext_vector = 8'h5A;
		core_eoi = 1'b0;
		core_init_clr = 4'h0;
		core_dest = 4'hB;
		core_prio = 16'h3035;
		failures = 0;
		comparisons = 0;
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		tick(1);
		check(entry_rd_q, 17'h1_0000);
		wr(17'h1_FFFF);
		check(entry_rd_q, 17'h1_AFFF);
		quiet();
		wr(17'h1_0042);
		quiet();
		check(pending_q, 17'h0_0000);
		foreach (modes[i]) begin
			m = modes[i];
			wr({6'h00, m, 8'h42});
			fire();
			check(s_int, (m == IOI_FIXED || m == IOI_EXT) ? 4'hB : (m == IOI_LOWEST) ? 4'h2 : 4'h0);
			check(s_nmi, (m == IOI_NMI) ? 4'hB : 4'h0);
			check(s_smi, (m == IOI_SMI) ? 4'hB : 4'h0);
			check(s_init, (m == IOI_INIT) ? 4'hB : 4'h0);
			check(s_vv, (m == IOI_SMI || m == IOI_NMI || m == IOI_INIT) ? 17'h0_0000 : 17'h0_0001);
			check(s_ext, (m == IOI_EXT) ? 17'h0_0001 : 17'h0_0000);
			check(s_vec, (m == IOI_FIXED || m == IOI_LOWEST) ? 8'h42 : 8'h00);
			if (m == IOI_INIT) begin
				check(core_in_init_q, 4'hB);
				@(posedge ref_clk);
				core_init_clr <= 4'hF;
				@(posedge ref_clk);
				core_init_clr <= 4'h0;
				tick(1);
				check(core_in_init_q, 4'h0);
			end
			if (m == IOI_EXT) begin
				check(core_vector_q, 8'h5A);
			end
		end
		wr({6'h00, 3'h3, 8'h42});
		check(cfg_err_q, 17'h0_0001);
		quiet();
		wr({6'h10, 3'h4, 8'h00});
		check(cfg_err_q, 17'h0_0001);
		wr({6'h00, 3'h0, 8'h0F});
		check(vec_range_err_q, 17'h0_0001);
		wr({6'h00, 3'h0, 8'hFE});
		check(vec_range_err_q, 17'h0_0000);
		wr({6'h10, 3'h0, 8'h42});
		fire();
		check(s_lvl, 17'h0_0001);
		check(entry_rd_q[14], 17'h0_0001);
		@(posedge ref_clk);
		core_eoi <= 1'b1;
		@(posedge ref_clk);
		core_eoi <= 1'b0;
		tick(4);
		check(entry_rd_q[14], 17'h0_0000);
		stop_test();
	end
endmodule
`default_nettype wire
